// file: inc/imt_map.svh
`ifndef IMT_MAP_SVH
`define IMT_MAP_SVH

// Sample, coefficient and index widths.
`define IMT_SAMPLE_W 16
`define IMT_COEF_W 16
`define IMT_IDX_W 4

// Spatial components in, intermediate and image components out.
`define IMT_NCOMP 4
`define IMT_NINT 4

// Output buffer depth in words.
`define IMT_FIFO_DEPTH 16

// Headroom bits added at each widening step.
`define IMT_GUARD_W 4

`endif

// file: inc/imt_pkg.sv
package imt_pkg;

	typedef enum logic [2:0] {
		IMT_CFG_DECOR_W,
		IMT_CFG_DECOR_OFS,
		IMT_CFG_DEP_W,
		IMT_CFG_DEP_OFS,
		IMT_CFG_IN_MAP,
		IMT_CFG_OUT_MAP,
		IMT_CFG_DEP_MAP,
		IMT_CFG_CLEAR
	} imt_cfg_t;

	typedef enum logic [2:0] {
		IMT_COLLECT,
		IMT_DECOR,
		IMT_DEP_INIT,
		IMT_DEPEND,
		IMT_PUSH
	} imt_state_t;

endpackage

// file: inc/imt_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "imt_map.svh"

interface imt_link_if #(
	parameter int SW = `IMT_SAMPLE_W,
	parameter int CW = `IMT_COEF_W,
	parameter int IW = `IMT_IDX_W
) (
	input wire logic i_clk
);
	import imt_pkg::*;

	logic cfg_valid;
	logic cfg_ready;
	imt_cfg_t cfg_sel;
	logic [IW-1:0] cfg_row;
	logic [IW-1:0] cfg_col;
	logic [CW-1:0] cfg_data;
	logic smp_valid;
	logic smp_ready;
	logic smp_last;
	logic [IW-1:0] smp_idx;
	logic [SW-1:0] smp_data;
	logic mct_en;
	logic vdc_en;

	modport dev (
		input cfg_valid, cfg_sel, cfg_row, cfg_col, cfg_data,
		input smp_valid, smp_last, smp_idx, smp_data, mct_en, vdc_en,
		output cfg_ready, smp_ready
	);

	modport src (
		output cfg_valid, cfg_sel, cfg_row, cfg_col, cfg_data,
		output smp_valid, smp_last, smp_idx, smp_data, mct_en, vdc_en,
		input cfg_ready, smp_ready
	);

endinterface

`default_nettype wire

// file: rtl/imt_dev.sv
// What this block does
// RULE1: Samples are column vectors, matrices multiply left.
// RULE2: Unset matrices default to identity or zero.
// RULE3: Intermediate row is weighted sum of inputs.
// RULE4: Add per-row decorrelation offset after weighting.
// RULE5: Input list maps columns to spatial components.
// RULE6: Output list maps rows to intermediate components.
// RULE7: Inputs and outputs may be reordered freely.
// RULE8: Encoder input lists cover every codestream component.
// RULE9: Decorrelation matrix may be non-square.
// RULE10: Transform applies only when capability flag set.
// RULE11: Never combined with variable offset extension.
// RULE12: Image component weights intermediate and earlier outputs.
// RULE13: Encoder supplies a square dependency matrix.
// RULE14: Encoder keeps dependency weights below diagonal.
// RULE15: Dependency outputs computed in causal order.
// RULE16: Encoder defines all reconstruction matrices.
// RULE17: Output is intermediate plus weighted earlier plus offset.
// RULE18: Dependency columns mapped by intermediate collection list.
// RULE19: Missing input component reads as all zeros.
// RULE20: Wide accumulation, outputs in final component order.
`timescale 1ns/1ps
`default_nettype none
`include "imt_map.svh"

module imt_fifo #(
	parameter int W = 8,
	parameter int DEPTH = `IMT_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Fill side.
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	// Drain side.
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW:0] cnt;
	} imt_fifo_st_t;

	imt_fifo_st_t s_q;
	imt_fifo_st_t s_d;
	logic push;
	logic pop;

	assign o_in_ready = s_q.cnt != (PW+1)'(DEPTH);
	assign o_out_valid = s_q.cnt != '0;
	assign o_out_data = s_q.mem[s_q.rd];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr] = i_in_data;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
		if (i_sys_rst) begin
			s_d.wr = '0;
			s_d.rd = '0;
			s_d.cnt = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		s_q <= s_d;
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module imt_dev
	import imt_pkg::*;
#(
	parameter int SW = `IMT_SAMPLE_W,
	parameter int CW = `IMT_COEF_W,
	parameter int IW = `IMT_IDX_W,
	parameter int NC = `IMT_NCOMP,
	parameter int NI = `IMT_NINT,
	parameter int DEPTH = `IMT_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Link from the spatial decoding stage.
	imt_link_if.dev link,
	// Image component output.
	output logic o_img_valid,
	input wire logic i_img_ready,
	output logic [IW-1:0] o_img_idx,
	output logic [SW+CW+`IMT_GUARD_W-1:0] o_img_data
);
	localparam int DW = SW + CW + `IMT_GUARD_W;
	localparam int AW = DW + CW + `IMT_GUARD_W;

	typedef struct packed {
		imt_state_t st;
		logic [NI-1:0][NC-1:0][CW-1:0] t;
		logic [NI-1:0][CW-1:0] m;
		logic [NI-1:0][NI-1:0][CW-1:0] r;
		logic [NI-1:0][CW-1:0] o;
		logic [NC-1:0][IW-1:0] in_map;
		logic [NI-1:0][IW-1:0] out_map;
		logic [NI-1:0][IW-1:0] dep_map;
		logic [NC-1:0][SW-1:0] rs;
		logic [NI-1:0][DW-1:0] w;
		logic [NI-1:0][DW-1:0] y;
		logic [IW-1:0] row;
		logic [IW-1:0] col;
		logic [AW-1:0] acc;
		logic bypass;
	} imt_dev_st_t;

	imt_dev_st_t s_q;
	imt_dev_st_t s_d;
	logic fifo_valid;
	logic fifo_ready;

	// Identity decorrelation, zero dependency and offsets, straight maps.
	function automatic imt_dev_st_t defaults(input imt_dev_st_t s);
		imt_dev_st_t v;
		v = s;
		v.t = '0;
		v.m = '0;
		v.r = '0;
		v.o = '0;
		for (int i = 0; i < NI; i++) begin
			if (i < NC) begin
				v.t[i][i] = CW'(1); // RULE2
			end
			v.out_map[i] = IW'(i);
			v.dep_map[i] = IW'(i);
		end
		for (int j = 0; j < NC; j++) begin
			v.in_map[j] = IW'(j);
		end
		return v;
	endfunction

	// Accumulator is wide enough that no column sum can overflow.
	function automatic logic [AW-1:0] mac(input logic [AW-1:0] a, input logic [CW-1:0] c,
		input logic [DW-1:0] x);
		logic signed [AW-1:0] p;
		p = AW'($signed(c) * $signed(x)); // RULE20
		return AW'($signed(a) + p);
	endfunction

	// Saturates the accumulator back to the component width.
	function automatic logic [DW-1:0] sat(input logic [AW-1:0] a);
		logic signed [AW-1:0] hi;
		logic signed [AW-1:0] lo;
		hi = AW'({1'b0, {(DW-1){1'b1}}});
		lo = ~hi;
		if ($signed(a) > hi) begin
			return {1'b0, {(DW-1){1'b1}}};
		end else if ($signed(a) < lo) begin
			return {1'b1, {(DW-1){1'b0}}};
		end
		return a[DW-1:0];
	endfunction

	assign link.cfg_ready = s_q.st == IMT_COLLECT;
	assign link.smp_ready = s_q.st == IMT_COLLECT;
	assign fifo_valid = s_q.st == IMT_PUSH;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [DW-1:0] x;
		logic [AW-1:0] a;
		x = '0;
		a = '0;
		s_d = s_q;
		case (s_q.st)
			IMT_COLLECT: begin
				if (link.cfg_valid) begin
					case (link.cfg_sel)
						IMT_CFG_DECOR_W: begin
							if (link.cfg_row < IW'(NI) && link.cfg_col < IW'(NC)) begin
								s_d.t[link.cfg_row][link.cfg_col] = link.cfg_data; // RULE9
							end
						end
						IMT_CFG_DECOR_OFS: begin
							if (link.cfg_row < IW'(NI)) begin
								s_d.m[link.cfg_row] = link.cfg_data;
							end
						end
						IMT_CFG_DEP_W: begin
							// Weights on or above the diagonal would break causality.
							if (link.cfg_row < IW'(NI) && link.cfg_col < link.cfg_row) begin
								s_d.r[link.cfg_row][link.cfg_col] = link.cfg_data; // RULE14
							end
						end
						IMT_CFG_DEP_OFS: begin
							if (link.cfg_row < IW'(NI)) begin
								s_d.o[link.cfg_row] = link.cfg_data;
							end
						end
						IMT_CFG_IN_MAP: begin
							if (link.cfg_row < IW'(NC)) begin
								s_d.in_map[link.cfg_row] = link.cfg_data[IW-1:0]; // RULE5 RULE7
							end
						end
						IMT_CFG_OUT_MAP: begin
							if (link.cfg_row < IW'(NI)) begin
								s_d.out_map[link.cfg_row] = link.cfg_data[IW-1:0]; // RULE6 RULE7
							end
						end
						IMT_CFG_DEP_MAP: begin
							if (link.cfg_row < IW'(NI)) begin
								s_d.dep_map[link.cfg_row] = link.cfg_data[IW-1:0]; // RULE18
							end
						end
						default: begin
							s_d = defaults(s_q); // RULE2
						end
					endcase
				end
				if (link.smp_valid) begin
					if (link.smp_idx < IW'(NC)) begin
						s_d.rs[link.smp_idx] = link.smp_data; // RULE1
					end
					if (link.smp_last) begin
						// Unsupported with the variable offset extension, so pass through.
						s_d.bypass = !link.mct_en || link.vdc_en; // RULE10 RULE11
						s_d.row = '0;
						s_d.col = '0;
						s_d.acc = AW'($signed(s_q.m[0])); // RULE4
						s_d.w = '0;
						// Only pass-through preloads; a row the output list drops reads zero.
						for (int i = 0; i < NI; i++) begin
							if (i < NC && s_d.bypass) begin
								s_d.w[i] = DW'($signed(s_d.rs[i])); // RULE19
							end
						end
						s_d.st = s_d.bypass ? IMT_DEP_INIT : IMT_DECOR;
					end
				end
			end
			IMT_DECOR: begin
				if (s_q.in_map[s_q.col] < IW'(NC)) begin
					x = DW'($signed(s_q.rs[s_q.in_map[s_q.col]]));
				end
				a = mac(s_q.acc, s_q.t[s_q.row][s_q.col], x); // RULE3 RULE19
				s_d.acc = a;
				s_d.col = s_q.col + 1'b1;
				if (s_q.col == IW'(NC - 1)) begin
					if (s_q.out_map[s_q.row] < IW'(NI)) begin
						s_d.w[s_q.out_map[s_q.row]] = sat(a); // RULE6
					end
					s_d.col = '0;
					if (s_q.row == IW'(NI - 1)) begin
						s_d.row = '0;
						s_d.st = IMT_DEP_INIT;
					end else begin
						s_d.row = s_q.row + 1'b1;
						s_d.acc = AW'($signed(s_q.m[s_q.row + 1'b1])); // RULE4
					end
				end
			end
			IMT_DEP_INIT: begin
				if (s_q.bypass) begin
					x = s_q.w[s_q.row];
				end else if (s_q.dep_map[s_q.row] < IW'(NI)) begin
					x = s_q.w[s_q.dep_map[s_q.row]]; // RULE18 RULE19
				end
				s_d.acc = AW'($signed(x));
				if (!s_q.bypass) begin
					s_d.acc = AW'($signed(s_d.acc) + $signed(s_q.o[s_q.row])); // RULE17
				end
				s_d.col = '0;
				s_d.st = IMT_DEPEND;
			end
			IMT_DEPEND: begin
				// Only earlier outputs are read, so one row per pass is causal.
				if (s_q.bypass || s_q.col == s_q.row) begin
					s_d.y[s_q.row] = sat(s_q.acc); // RULE15
					s_d.st = IMT_PUSH;
				end else begin
					s_d.acc = mac(s_q.acc, s_q.r[s_q.row][s_q.col], s_q.y[s_q.col]); // RULE12
					s_d.col = s_q.col + 1'b1;
				end
			end
			IMT_PUSH: begin
				if (fifo_ready) begin
					if (s_q.row == IW'(NI - 1)) begin
						s_d.st = IMT_COLLECT;
					end else begin
						s_d.row = s_q.row + 1'b1;
						s_d.st = IMT_DEP_INIT;
					end
				end
			end
			default: begin
				s_d.st = IMT_COLLECT;
			end
		endcase
		if (i_sys_rst) begin
			s_d = defaults(s_q);
			s_d.st = IMT_COLLECT;
			s_d.rs = '0;
			s_d.w = '0;
			s_d.y = '0;
			s_d.row = '0;
			s_d.col = '0;
			s_d.acc = '0;
			s_d.bypass = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////////////

	// A stalled consumer holds the engine in its push state.
	imt_fifo #(
		.W(IW + DW),
		.DEPTH(DEPTH)
	) u_out_fifo (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(fifo_valid),
		.o_in_ready(fifo_ready),
		.i_in_data({s_q.row, s_q.y[s_q.row]}), // RULE20
		.o_out_valid(o_img_valid),
		.i_out_ready(i_img_ready),
		.o_out_data({o_img_idx, o_img_data})
	);
endmodule

`default_nettype wire

// file: rtl/imt_src.sv
`timescale 1ns/1ps
`default_nettype none
`include "imt_map.svh"

module imt_src
	import imt_pkg::*;
#(
	parameter int SW = `IMT_SAMPLE_W,
	parameter int CW = `IMT_COEF_W,
	parameter int IW = `IMT_IDX_W,
	parameter int NI = `IMT_NINT
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Matrix configuration requests.
	input wire logic i_cfg_valid,
	output logic o_cfg_ready,
	input wire imt_cfg_t i_cfg_sel,
	input wire logic [IW-1:0] i_cfg_row,
	input wire logic [IW-1:0] i_cfg_col,
	input wire logic [CW-1:0] i_cfg_data,
	// Spatially reconstructed samples.
	input wire logic i_smp_valid,
	output logic o_smp_ready,
	input wire logic i_smp_last,
	input wire logic [IW-1:0] i_smp_idx,
	input wire logic [SW-1:0] i_smp_data,
	// Capability flags.
	input wire logic i_mct_en,
	input wire logic i_vdc_en,
	// Link to the transform.
	imt_link_if.src link
);
	typedef struct packed {
		logic cv;
		imt_cfg_t sel;
		logic [IW-1:0] row;
		logic [IW-1:0] col;
		logic [CW-1:0] data;
		logic sv;
		logic last;
		logic [IW-1:0] idx;
		logic [SW-1:0] smp;
		logic transform_matrix_segment;
		logic vdc;
	} imt_src_st_t;

	imt_src_st_t s_q;
	imt_src_st_t s_d;

	assign o_cfg_ready = !s_q.cv || link.cfg_ready;
	assign o_smp_ready = !s_q.sv || link.smp_ready;
	assign link.cfg_valid = s_q.cv;
	assign link.cfg_sel = s_q.sel;
	assign link.cfg_row = s_q.row;
	assign link.cfg_col = s_q.col;
	assign link.cfg_data = s_q.data;
	assign link.smp_valid = s_q.sv;
	assign link.smp_last = s_q.last;
	assign link.smp_idx = s_q.idx;
	assign link.smp_data = s_q.smp;
	assign link.mct_en = s_q.transform_matrix_segment;
	assign link.vdc_en = s_q.vdc;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		s_d = s_q;
		// The two extensions are exclusive; variable offset wins.
		s_d.transform_matrix_segment = i_mct_en && !i_vdc_en; // RULE11
		s_d.vdc = i_vdc_en;
		if (s_q.cv && link.cfg_ready) begin
			s_d.cv = 1'b0;
		end
		if (i_cfg_valid && o_cfg_ready) begin
			s_d.cv = 1'b1; // RULE16
			s_d.sel = i_cfg_sel;
			s_d.row = i_cfg_row;
			s_d.col = i_cfg_col;
			s_d.data = i_cfg_data;
			// Dependency weights must be square and strictly lower.
			if (i_cfg_sel == IMT_CFG_DEP_W) begin
				if (i_cfg_col >= i_cfg_row || i_cfg_row >= IW'(NI)) begin
					s_d.data = '0; // RULE13 RULE14
				end
			end
		end
		if (s_q.sv && link.smp_ready) begin
			s_d.sv = 1'b0;
		end
		if (i_smp_valid && o_smp_ready) begin
			s_d.sv = 1'b1; // RULE8
			s_d.last = i_smp_last;
			s_d.idx = i_smp_idx;
			s_d.smp = i_smp_data;
		end
		if (i_sys_rst) begin
			s_d = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		s_q <= s_d;
	end
endmodule

`default_nettype wire

// file: tb/imt_link_props.sv
`timescale 1ns/1ps
`default_nettype none

module imt_link_props
	import imt_pkg::*;
#(
	parameter int SW = 16,
	parameter int CW = 16,
	parameter int IW = 4
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Configuration handshake.
	input wire logic cfg_valid,
	input wire logic cfg_ready,
	input wire imt_cfg_t cfg_sel,
	input wire logic [IW-1:0] cfg_row,
	input wire logic [IW-1:0] cfg_col,
	input wire logic [CW-1:0] cfg_data,
	// Sample handshake.
	input wire logic smp_valid,
	input wire logic smp_ready,
	input wire logic smp_last,
	input wire logic [IW-1:0] smp_idx,
	input wire logic [SW-1:0] smp_data,
	// Capability flags.
	input wire logic mct_en,
	input wire logic vdc_en
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	////////////////////////////////////////
	chk_cfg_hold: assert property (cfg_valid && !cfg_ready |=>
		cfg_valid && $stable({cfg_sel, cfg_row, cfg_col, cfg_data}))
		else $error("config request changed before accept");
	chk_smp_hold: assert property (smp_valid && !smp_ready |=>
		smp_valid && $stable({smp_last, smp_idx, smp_data}))
		else $error("sample changed before accept");
	chk_busy_after_last: assert property (smp_valid && smp_ready && smp_last |=>
		!smp_ready [*8])
		else $error("engine took input during compute");
	// The long stall test must stay well inside this bound.
	chk_busy_bound: assert property ($fell(smp_ready) |-> ##[1:1000] smp_ready)
		else $error("engine never returned to collect");
	chk_ready_pair: assert property (cfg_ready == smp_ready)
		else $error("config and sample ready differ");
	chk_no_combo: assert property (!(mct_en && vdc_en))
		else $error("transform enabled with variable offset");
	chk_dep_causal: assert property (cfg_valid && cfg_sel == IMT_CFG_DEP_W &&
		cfg_col >= cfg_row |-> cfg_data == '0)
		else $error("dependency weight on or above diagonal");
	chk_reset_idle: assert property ($fell(i_sys_rst) |->
		!cfg_valid && !smp_valid && cfg_ready && smp_ready)
		else $error("link not idle after reset");
endmodule

`default_nettype wire

// file: tb/inverse_multicomponent_transform_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "imt_map.svh"

module inverse_multicomponent_transform_tb;
	import imt_pkg::*;
	localparam int DW = `IMT_SAMPLE_W + `IMT_COEF_W + `IMT_GUARD_W;
	typedef struct {
		imt_cfg_t sel;
		logic [3:0] row;
		logic [3:0] col;
		logic [15:0] data;
		logic transform_matrix_segment;
		logic vdc;
		int y[4];
	} imt_row_t;

	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic cfg_valid = 1'b0, cfg_ready, smp_valid = 1'b0, smp_ready, smp_last = 1'b0;
	logic mct_en = 1'b1, vdc_en = 1'b0, img_valid, img_ready = 1'b0;
	imt_cfg_t cfg_sel = IMT_CFG_CLEAR;
	logic [3:0] cfg_row = 4'h0, cfg_col = 4'h0, smp_idx = 4'h0, img_idx;
	logic [15:0] cfg_data = 16'h0000, smp_data = 16'h0000;
	logic [DW-1:0] img_data;
	int miscompares = 0;
	int n_checks = 0;
	int rv[4] = '{5, 7, 11, 13};
	// Rows build on each other, so each expectation holds the tables left by the rows above.
	imt_row_t rows[13] = '{
		'{IMT_CFG_DECOR_W, 4'h0, 4'h1, 16'h0002, 1, 0, '{19, 7, 11, 13}},
		'{IMT_CFG_DECOR_OFS, 4'h0, 4'h0, 16'h0003, 1, 0, '{22, 7, 11, 13}},
		'{IMT_CFG_DEP_W, 4'h1, 4'h0, 16'h0001, 1, 0, '{22, 29, 11, 13}},
		'{IMT_CFG_DEP_OFS, 4'h3, 4'h0, 16'hffff, 1, 0, '{22, 29, 11, 12}},
		'{IMT_CFG_DEP_W, 4'h2, 4'h3, 16'h0005, 1, 0, '{22, 29, 11, 12}},
		'{IMT_CFG_IN_MAP, 4'h0, 4'h0, 16'h0002, 1, 0, '{28, 35, 11, 12}},
		'{IMT_CFG_OUT_MAP, 4'h3, 4'h0, 16'h000f, 1, 0, '{28, 35, 11, -1}},
		'{IMT_CFG_DEP_MAP, 4'h2, 4'h0, 16'h0000, 1, 0, '{28, 35, 28, -1}},
		'{IMT_CFG_IN_MAP, 4'h1, 4'h0, 16'h0009, 1, 0, '{14, 14, 14, -1}},
		'{IMT_CFG_CLEAR, 4'h0, 4'h0, 16'h0000, 1, 0, '{5, 7, 11, 13}},
		'{IMT_CFG_DECOR_W, 4'h0, 4'h1, 16'h0002, 0, 0, '{5, 7, 11, 13}},
		'{IMT_CFG_DECOR_W, 4'h0, 4'h1, 16'h0002, 1, 1, '{5, 7, 11, 13}},
		'{IMT_CFG_DECOR_W, 4'h0, 4'h1, 16'h0002, 1, 0, '{19, 7, 11, 13}}
	};

	always #20 i_clk = ~i_clk;

	////////////////////////////////////////
	imt_link_if u_imt_link_if (.i_clk(i_clk));
	imt_src u_imt_src (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg_valid(cfg_valid),
		.o_cfg_ready(cfg_ready), .i_cfg_sel(cfg_sel), .i_cfg_row(cfg_row), .i_cfg_col(cfg_col),
		.i_cfg_data(cfg_data), .i_smp_valid(smp_valid), .o_smp_ready(smp_ready),
		.i_smp_last(smp_last), .i_smp_idx(smp_idx), .i_smp_data(smp_data), .i_mct_en(mct_en),
		.i_vdc_en(vdc_en), .link(u_imt_link_if));
	imt_dev u_imt_dev (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(u_imt_link_if),
		.o_img_valid(img_valid), .i_img_ready(img_ready), .o_img_idx(img_idx),
		.o_img_data(img_data));
	imt_link_props u_imt_link_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.cfg_valid(u_imt_link_if.cfg_valid), .cfg_ready(u_imt_link_if.cfg_ready),
		.cfg_sel(u_imt_link_if.cfg_sel), .cfg_row(u_imt_link_if.cfg_row),
		.cfg_col(u_imt_link_if.cfg_col), .cfg_data(u_imt_link_if.cfg_data),
		.smp_valid(u_imt_link_if.smp_valid), .smp_ready(u_imt_link_if.smp_ready),
		.smp_last(u_imt_link_if.smp_last), .smp_idx(u_imt_link_if.smp_idx),
		.smp_data(u_imt_link_if.smp_data), .mct_en(u_imt_link_if.mct_en),
		.vdc_en(u_imt_link_if.vdc_en));

	////////////////////////////////////////
	task automatic tally_and_finish;
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [3:0] gi, input logic [DW-1:0] gd,
		input logic [3:0] ei, input logic [DW-1:0] ed);
		n_checks++;
		if (gi !== ei || gd !== ed) begin
			miscompares++;
			$display("FAIL %0t word %0d %0h, want %0d %0h", $time, gi, gd, ei, ed);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t flag %b, want %b", $time, got, exp);
		end
	endtask

	task automatic send_cfg(input imt_cfg_t s, input logic [3:0] r, input logic [3:0] c,
		input logic [15:0] d);
		int n;
		@(posedge i_clk);
		#1;
		cfg_sel = s;
		cfg_row = r;
		cfg_col = c;
		cfg_data = d;
		cfg_valid = 1'b1;
		n = 0;
		while (!cfg_ready && n < 2000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n >= 2000) begin
			miscompares++;
		end
		@(posedge i_clk);
		#1;
		cfg_valid = 1'b0;
	endtask

	task automatic send_vec(input int r[4]);
		int n;
		@(posedge i_clk);
		#1;
		for (int i = 0; i < 4; i++) begin
			smp_valid = 1'b1;
			smp_idx = 4'(i);
			smp_data = 16'(r[i]);
			smp_last = (i == 3);
			n = 0;
			while (!smp_ready && n < 2000) begin
				@(posedge i_clk);
				#1;
				n++;
			end
			if (n >= 2000) begin
				miscompares++;
			end
			@(posedge i_clk);
			#1;
		end
		smp_valid = 1'b0;
		smp_last = 1'b0;
	endtask

	// Ready stays high after reading, so back-to-back reads never drop and raise it in one step.
	task automatic get_vec(input int y[4]);
		int n;
		img_ready = 1'b1;
		for (int i = 0; i < 4; i++) begin
			n = 0;
			while (!img_valid && n < 2000) begin
				@(posedge i_clk);
				#1;
				n++;
			end
			if (n >= 2000) begin
				miscompares++;
			end
			chk_word(img_idx, img_data, 4'(i), DW'(y[i]));
			@(posedge i_clk);
			#1;
		end
	endtask

	////////////////////////////////////////
	initial begin
		#(8000 * 40);
		miscompares++;
		$display("FAIL %0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		repeat (2) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		chk_bit(cfg_ready, 1'b1);
		chk_bit(img_valid, 1'b0);
		foreach (rows[k]) begin
			mct_en = rows[k].transform_matrix_segment;
			vdc_en = rows[k].vdc;
			send_cfg(rows[k].sel, rows[k].row, rows[k].col, rows[k].data);
			send_vec(rv);
			get_vec(rows[k].y);
		end
		// With ready low four vectors fill the buffer; reads begin before the fifth reaches its push state.
		img_ready = 1'b0;
		send_cfg(IMT_CFG_CLEAR, 4'h0, 4'h0, 16'h0000);
		for (int k = 0; k < 5; k++) begin
			send_vec('{k, k + 1, k + 2, k + 3});
		end
		send_cfg(IMT_CFG_CLEAR, 4'h0, 4'h0, 16'h0000);
		chk_bit(img_valid, 1'b1);
		for (int k = 0; k < 5; k++) begin
			get_vec('{k, k + 1, k + 2, k + 3});
		end
		send_vec(rv);
		repeat (5) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		chk_bit(img_valid, 1'b0);
		chk_bit(smp_ready, 1'b1);
		send_vec(rv);
		get_vec(rv);
		tally_and_finish();
	end
endmodule

`default_nettype wire
